// *** dv/psu_setup_top_tb_top.sv ***
// Self-checking bench of the primitive setup unit
module psu_setup_top_tb_top import psu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
    logic hready, hreadyout, hresp, dn_valid, dn_ready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, lfsr = 32'h1b01, hrdata, md, cw, xd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    psu_msg_t dn_msg;
    logic [31:0] rq[$];
    psu_msg_t mq[$];
    int mismatches = 0, checks_done = 0;
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    psu_setup_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dn_msg(dn_msg),
        .dn_valid(dn_valid), .dn_ready(dn_ready));
    psu_sink sink (.hclk(hclk), .hresetn(hresetn), .dn_valid(dn_valid), .dn_ready(dn_ready));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd(input logic [31:0] s);
        rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : rnd
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (!hready);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !w;
        do @(posedge hclk); while (!hready);
        rd_ph <= 1'b0;
    endtask : bus
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        if (rd_ph && hready) check({7'h0, hresp, hrdata}, {8'h0, rq.pop_front()});
        if (dn_valid && dn_ready && |dn_msg.tag[7:6]) check(dn_msg, mq.pop_front());
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rq.push_back(MODE_RST);
        bus(32'(A_MODE), 1'b0, 32'h0);
        rq.push_back(32'h0);
        bus(32'h100, 1'b0, 32'h0);
        // Every parameter gets a value so no unwritten storage reaches downstream
        for (int v = 0; v < 3; v++) begin
            for (int p = 0; p < 16; p++) begin
                lfsr = rnd(lfsr);
                bus(32'h200 + v * 64 + p * 4, 1'b1, lfsr);
            end
        end
        bus(32'h400 + {P_S, 2'h0}, 1'b1, 32'h40000000);
        rq.push_back(F_ONE);
        bus(32'h200 + {P_S, 2'h0}, 1'b0, 32'h0);
        // Equal coordinates give zero area, so culling never drops a primitive
        for (int v = 0; v < 3; v++) begin
            bus(32'h400 + v * 64 + {P_X, 2'h0}, 1'b1, 32'h00010000);
            bus(32'h200 + v * 64 + {P_Y, 2'h0}, 1'b1, 32'h7fc00000);
        end
        rq.push_back(F_ONE);
        bus(32'h240 + {P_X, 2'h0}, 1'b0, 32'h0);
        rq.push_back(32'h0);
        bus(32'h280 + {P_Y, 2'h0}, 1'b0, 32'h0);
        for (int i = 0; i < 4; i++) begin
            lfsr = rnd(lfsr);
            md = {lfsr[31:13], i[0], lfsr[11:0]};
            cw = rnd(lfsr);
            lfsr = rnd(cw);
            xd = 32'h0;
            xd[X_DIAM] = md[M_DIAM];
            xd[X_FINEY] = md[M_FINEY] && cw[C_FINEY];
            xd[X_ZW+:2] = md[M_ZW+:2];
            xd[X_CORD] = md[M_CORD];
            xd[X_LINE] = i > 1;
            xd[X_REV] = i == 3;
            bus(32'(A_MODE), 1'b1, md);
            rq.push_back(md & MODE_MASK);
            bus(32'(A_MODE), 1'b0, 32'h0);
            mq.push_back({T_EXTRA, xd});
            if (!md[M_SUPPRESS_RENDER]) mq.push_back({T_RENDER, cw});
            if (!md[M_SUPPRESS_RENDER]) mq.push_back({T_CONT, 32'h0});
            bus(32'(i < 2 ? A_TRI : (i[0] ? A_LREV : A_LFWD)), 1'b1, cw);
            // A later mode write and a different data word must not reach the redo
            bus(32'(A_MODE), 1'b1, lfsr);
            mq.push_back({T_EXTRA, xd});
            mq.push_back({T_RENDER, cw});
            mq.push_back({T_CONT, 32'h0});
            bus(32'(i < 2 ? A_TRI_REDO : A_LREDO), 1'b1, lfsr);
        end
        bus(32'(A_MODE), 1'b1, 32'h1 << M_CULL);
        for (int v = 0; v < 3; v++) begin
            bus(32'h200 + v * 64 + {P_X, 2'h0}, 1'b1, v == 1 ? F_ONE : 32'h0);
            bus(32'h200 + v * 64 + {P_Y, 2'h0}, 1'b1, v == 2 ? F_ONE : 32'h0);
        end
        // Positive area with the negative-face bit clear is dropped silently
        bus(32'(A_TRI), 1'b1, 32'h0);
        repeat (8) @(posedge hclk);
        rq.push_back(32'h2);
        bus(32'(A_STAT), 1'b0, 32'h0);
        mq.push_back({T_EXTRA, 32'h0});
        mq.push_back({T_RENDER, 32'h1 << C_NEG});
        mq.push_back({T_CONT, 32'h0});
        bus(32'(A_TRI), 1'b1, 32'h1 << C_NEG);
        repeat (300) @(posedge hclk);
        rq.push_back(32'h0);
        bus(32'(A_STAT), 1'b0, 32'h0);
        check(40'(mq.size()), 40'h0);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        final_report();
    end
endmodule : psu_setup_top_tb_top

// *** dv/psu_sink.sv ***
// Downstream consumer model that accepts on a fixed stall pattern
module psu_sink (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dn_valid,
    output logic dn_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;
    // One accept in three valid cycles, so every held message meets a stall
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 2'h0;
            dn_ready <= 1'b0;
        end else if (dn_valid) begin
            cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
            dn_ready <= (cnt == 2'h1);
        end
    end
endmodule : psu_sink

// *** verilog/psu_param_conv.sv ***
// Vertex parameter conversion to clamped single-precision float
module psu_param_conv import psu_pkg::*; (
    input wire logic [31:0] raw,
    input wire logic is_fixed,
    input wire logic [3:0] param,
    input wire logic limit_en,
    input wire logic tex_clamp,
    output logic [31:0] flt
);
    always_comb begin
        logic [31:0] mag;
        logic [31:0] sh;
        logic [31:0] v;
        logic [31:0] hi;
        logic [9:0] e;
        logic [4:0] m;
        logic sgn;
        mag = raw;
        sh = 32'h0;
        v = raw;
        hi = psu_hi(param);
        e = 10'h0;
        m = 5'h0;
        sgn = 1'b0;
        if (is_fixed) begin
            sgn = psu_signed(param) && raw[31];
            mag = sgn ? 32'(-raw) : raw;
            for (int i = 0; i < 32; i++) begin
                if (mag[i]) begin
                    m = 5'(i);
                end
            end
            e = EXP_BIAS + 10'(m) - 10'(psu_frac(param));
            sh = mag << (5'h1f - m);
            v = (mag == 32'h0) ? 32'h0 : {sgn, e[7:0], sh[30:8]};
        end else if (raw[30:23] == 8'h0) begin
            v = 32'h0;
        end else if (raw[30:23] == EXP_NAN && raw[22:0] != 23'h0) begin
            v = 32'h0;
        end else if (raw[30:23] >= EXP_LIM) begin
            v = {raw[31], F_BIG[30:0]};
        end
        // Texture inputs obey the texture mode only, never the general clamp
        if (param > P_Z) begin
            flt = raw;
        end else if ((param <= P_Q) ? tex_clamp : limit_en) begin
            if (!v[31] && v[30:0] > hi[30:0]) begin
                flt = hi;
            end else if (v[31] && !psu_signed(param)) begin
                flt = 32'h0;
            end else if (v[31] && v[30:0] > hi[30:0]) begin
                flt = {1'b1, hi[30:0]};
            end else begin
                flt = v;
            end
        end else begin
            flt = v;
        end
    end
endmodule : psu_param_conv

// *** verilog/psu_pkg.sv ***
// Constants, types and helper functions shared by the primitive setup unit
package psu_pkg;
    localparam logic [11:0] A_MODE = 12'h000;
    localparam logic [11:0] A_STAT = 12'h004;
    localparam logic [11:0] A_TRI = 12'h010;
    localparam logic [11:0] A_TRI_REDO = 12'h014;
    localparam logic [11:0] A_LFWD = 12'h018;
    localparam logic [11:0] A_LREV = 12'h01c;
    localparam logic [11:0] A_LREDO = 12'h020;
    localparam logic [2:0] WIN_FLT = 3'h1;
    localparam logic [2:0] WIN_FIX = 3'h2;
    localparam logic [31:0] MODE_RST = 32'h00000000;
    localparam logic [31:0] MODE_MASK = 32'h0006fffc;
    localparam int M_ZW = 2;
    localparam int M_FOG = 4;
    localparam int M_TEX = 5;
    localparam int M_COL = 6;
    localparam int M_Z = 7;
    localparam int M_SPEC = 8;
    localparam int M_DIFF = 9;
    localparam int M_FINEY = 10;
    localparam int M_DIAM = 11;
    localparam int M_SUPPRESS_RENDER = 12;
    localparam int M_LIMIT = 13;
    localparam int M_TEXP = 14;
    localparam int M_CULL = 17;
    localparam int M_CORD = 18;
    localparam int C_TEX = 13;
    localparam int C_FOG = 14;
    localparam int C_FINEY = 16;
    localparam int C_NEG = 20;
    localparam logic [1:0] TEXP_GIVEN = 2'h0;
    localparam logic [1:0] TEXP_CLAMP = 2'h1;
    localparam logic [1:0] TEXP_NORM = 2'h2;
    localparam logic [3:0] P_S = 4'h0;
    localparam logic [3:0] P_Q = 4'h2;
    localparam logic [3:0] P_KS = 4'h3;
    localparam logic [3:0] P_KD = 4'h4;
    localparam logic [3:0] P_R = 4'h5;
    localparam logic [3:0] P_A = 4'h8;
    localparam logic [3:0] P_FOG = 4'h9;
    localparam logic [3:0] P_X = 4'ha;
    localparam logic [3:0] P_Y = 4'hb;
    localparam logic [3:0] P_Z = 4'hc;
    localparam logic [31:0] F_ONE = 32'h3f800000;
    localparam logic [31:0] F_TWO = 32'h40000000;
    localparam logic [31:0] F_512 = 32'h44000000;
    localparam logic [31:0] F_32K = 32'h47000000;
    localparam logic [31:0] F_BIG = 32'h4f800000;
    localparam logic [7:0] EXP_LIM = 8'h9f;
    localparam logic [7:0] EXP_NAN = 8'hff;
    localparam logic [9:0] EXP_BIAS = 10'h07f;
    localparam logic [9:0] EXP_HALF = 10'h07e;
    localparam logic [7:0] FX_EXP = 8'h86;
    localparam logic [7:0] T_EXTRA = 8'h40;
    localparam logic [7:0] T_RENDER = 8'h80;
    localparam logic [7:0] T_CONT = 8'h81;
    localparam int X_DIAM = 0;
    localparam int X_FINEY = 1;
    localparam int X_ZW = 2;
    localparam int X_CORD = 4;
    localparam int X_LINE = 5;
    localparam int X_REV = 6;
    localparam int ST_BUSY = 0;
    localparam int ST_CULLED = 1;

    typedef enum logic [1:0] {K_TRI, K_LFWD, K_LREV} psu_kind_t;
    typedef enum logic [2:0] {S_IDLE, S_CULL, S_PARAM, S_EXTRA, S_RENDER, S_CONT} psu_state_t;
    typedef struct packed {
        logic [7:0] tag;
        logic [31:0] data;
    } psu_msg_t;

    // Fraction bits of each parameter's fixed-point input form
    function automatic logic [5:0] psu_frac(input logic [3:0] p);
        case (p)
            P_KS, P_KD, P_FOG: psu_frac = 6'h16;
            P_X, P_Y: psu_frac = 6'h10;
            default: psu_frac = 6'h1e;
        endcase
    endfunction : psu_frac

    function automatic logic psu_signed(input logic [3:0] p);
        psu_signed = (p <= P_Q) || (p == P_FOG) || (p == P_X) || (p == P_Y);
    endfunction : psu_signed

    // Upper limit; signed parameters use the same magnitude below zero
    function automatic logic [31:0] psu_hi(input logic [3:0] p);
        case (p)
            P_KS: psu_hi = F_TWO;
            P_FOG: psu_hi = F_512;
            P_X, P_Y: psu_hi = F_32K;
            default: psu_hi = F_ONE;
        endcase
    endfunction : psu_hi
endpackage : psu_pkg

// *** verilog/psu_setup_top.sv ***
// Primitive setup unit: AHB-Lite registers, vertex store and setup sequencer
module psu_setup_top import psu_pkg::*; #(
    parameter int NV = 3,
    parameter int NP = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output psu_msg_t dn_msg,
    output logic dn_valid,
    input wire logic dn_ready
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [31:0] mode;
    logic [31:0] held_mode;
    logic [31:0] held_cmd;
    psu_kind_t held_kind;
    logic cur_draw;
    logic culled;
    logic [31:0] vtx [NV][NP];
    logic [31:0] snap [NV][NP];
    psu_state_t st;
    logic [3:0] p_idx;
    logic [1:0] ph;
    logic dp_wr;
    logic [11:0] dp_addr;
    logic [31:0] conv_out;
    logic accept;
    logic launch;
    logic dp_cmd;
    logic dp_vtx;
    logic [1:0] dp_v;
    logic [3:0] dp_p;
    logic cmd_draw;
    logic free;

    assign accept = hsel && htrans[1] && hready;
    assign dp_v = dp_addr[7:6];
    assign dp_p = dp_addr[5:2];
    assign dp_vtx = dp_wr && (dp_addr[11:9] == WIN_FLT || dp_addr[11:9] == WIN_FIX)
        && (32'(dp_v) < NV);
    assign dp_cmd = dp_wr && (dp_addr == A_TRI || dp_addr == A_TRI_REDO ||
        dp_addr == A_LFWD || dp_addr == A_LREV || dp_addr == A_LREDO);
    assign cmd_draw = dp_addr == A_TRI || dp_addr == A_LFWD || dp_addr == A_LREV;
    // Command waits in its data phase until the sequencer is idle
    assign launch = dp_cmd && !hreadyout && st == S_IDLE;
    assign free = !dn_valid || dn_ready;

    psu_param_conv u_conv (
        .raw(hwdata),
        .is_fixed(dp_addr[11:9] == WIN_FIX),
        .param(dp_p),
        .limit_en(mode[M_LIMIT]),
        .tex_clamp(mode[M_TEXP+:2] == TEXP_CLAMP),
        .flt(conv_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_addr <= 12'h0;
        end else if (hready) begin
            dp_wr <= accept && hwrite;
            dp_addr <= {haddr[11:2], 2'b00};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else if (accept && hwrite && (haddr[11:0] == A_TRI || haddr[11:0] == A_TRI_REDO
                || haddr[11:0] == A_LFWD || haddr[11:0] == A_LREV || haddr[11:0] == A_LREDO)) begin
            hreadyout <= 1'b0;
        end else if (launch) begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // Read data is registered in the address phase; a write still in its
    // data phase to the same address is forwarded; a read of that word through the other window is not
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (accept && !hwrite) begin
            if (dp_wr && dp_addr == {haddr[11:2], 2'b00} && dp_vtx) begin
                hrdata <= conv_out;
            end else if (dp_wr && haddr[11:0] == A_MODE && dp_addr == A_MODE) begin
                hrdata <= hwdata & MODE_MASK;
            end else if (haddr[11:0] == A_MODE) begin
                hrdata <= mode;
            end else if (haddr[11:0] == A_STAT) begin
                hrdata <= {30'h0, culled, st != S_IDLE};
            end else if ((haddr[11:9] == WIN_FLT || haddr[11:9] == WIN_FIX)
                    && 32'(haddr[7:6]) < NV) begin
                hrdata <= vtx[haddr[7:6]][haddr[5:2]];
            end else begin
                hrdata <= 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and vertex storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= MODE_RST;
        end else if (dp_wr && dp_addr == A_MODE) begin
            mode <= hwdata & MODE_MASK;
        end
    end

    always_ff @(posedge hclk) begin
        if (dp_vtx) begin
            vtx[dp_v][dp_p] <= conv_out;
        end
    end

    // Draw captures vertices, command data and mode; redo reuses them
    always_ff @(posedge hclk) begin
        if (launch && cmd_draw) begin
            snap <= vtx;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held_mode <= MODE_RST;
            held_cmd <= 32'h0;
            held_kind <= K_TRI;
            cur_draw <= 1'b0;
        end else if (launch) begin
            cur_draw <= cmd_draw;
            if (cmd_draw) begin
                held_mode <= mode;
                held_cmd <= hwdata;
                held_kind <= (dp_addr == A_TRI) ? K_TRI :
                    (dp_addr == A_LFWD) ? K_LFWD : K_LREV;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Setup arithmetic
    function automatic logic signed [34:0] f2x(input logic [31:0] f);
        logic [33:0] mg;
        mg = {10'h0, 1'b1, f[22:0]};
        if (f[30:23] == 8'h0) begin
            mg = 34'h0;
        end else if (f[30:23] >= FX_EXP) begin
            mg = mg << (f[30:23] - FX_EXP);
        end else begin
            mg = mg >> (FX_EXP - f[30:23]);
        end
        f2x = f[31] ? -$signed({1'b0, mg}) : $signed({1'b0, mg});
    endfunction : f2x

    logic [1:0] vs;
    logic [1:0] vb;
    logic [1:0] vc;
    logic [1:0] vsel;
    logic signed [70:0] area;
    logic cull_hit;
    logic [30:0] tex_max;
    logic signed [9:0] tex_k;
    logic [31:0] raw_val;
    logic [31:0] out_val;
    logic p_en;

    always_comb begin
        case (held_kind)
            K_LFWD: begin
                vs = 2'h0;
                vb = 2'h1;
                vc = 2'h1;
            end
            K_LREV: begin
                vs = 2'h1;
                vb = 2'h0;
                vc = 2'h0;
            end
            default: begin
                vs = 2'h0;
                vb = 2'h1;
                vc = 2'h2;
            end
        endcase
        vsel = (ph == 2'h0) ? vs : (ph == 2'h1) ? vb : vc;
    end

    assign area = 71'((f2x(snap[vb][P_X]) - f2x(snap[vs][P_X])) * (f2x(snap[vc][P_Y])
        - f2x(snap[vs][P_Y]))) - 71'((f2x(snap[vc][P_X]) - f2x(snap[vs][P_X]))
        * (f2x(snap[vb][P_Y]) - f2x(snap[vs][P_Y])));
    assign cull_hit = held_kind == K_TRI && held_mode[M_CULL] &&
        (held_cmd[C_NEG] ? area < 0 : area > 0);

    // Largest texture magnitude over the primitive's own vertices only
    always_comb begin
        tex_max = 31'h0;
        for (int v = 0; v < NV; v++) begin
            for (int p = 0; p <= int'(P_Q); p++) begin
                if ((held_kind == K_TRI || v < 2) && snap[v][p][30:0] > tex_max) begin
                    tex_max = snap[v][p][30:0];
                end
            end
        end
        tex_k = $signed({2'b00, tex_max[30:23]}) - $signed((tex_max[22:0] != 23'h0) ?
            EXP_HALF : EXP_BIAS);
    end

    // Power-of-two scaling keeps precision and lands the peak at one or below
    always_comb begin
        logic signed [9:0] ne;
        raw_val = snap[vsel][p_idx];
        ne = $signed({2'b00, raw_val[30:23]}) - tex_k;
        out_val = raw_val;
        if (p_idx <= P_Q && held_mode[M_TEXP+:2] == TEXP_NORM && tex_max != 31'h0) begin
            if (raw_val[30:23] == 8'h0 || ne <= 0) begin
                out_val = 32'h0;
            end else begin
                out_val = {raw_val[31], ne[7:0], raw_val[22:0]};
            end
        end
    end

    always_comb begin
        case (p_idx)
            4'h0, 4'h1, P_Q: p_en = held_cmd[C_TEX] && held_mode[M_TEX];
            P_KS: p_en = held_mode[M_SPEC];
            P_KD: p_en = held_mode[M_DIFF];
            4'h5, 4'h6, 4'h7, P_A: p_en = held_mode[M_COL];
            P_FOG: p_en = held_cmd[C_FOG] && held_mode[M_FOG];
            P_Z: p_en = held_mode[M_Z];
            default: p_en = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer and downstream message port
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= S_IDLE;
            p_idx <= 4'h0;
            ph <= 2'h0;
            culled <= 1'b0;
            dn_valid <= 1'b0;
            dn_msg <= '0;
        end else begin
            if (free) begin
                dn_valid <= 1'b0;
            end
            case (st)
                S_IDLE: begin
                    if (launch) begin
                        st <= S_CULL;
                    end
                end
                S_CULL: begin
                    p_idx <= P_S;
                    ph <= 2'h0;
                    culled <= cull_hit;
                    st <= cull_hit ? S_IDLE : S_PARAM;
                end
                S_PARAM: begin
                    if (free) begin
                        if (p_en) begin
                            dn_valid <= 1'b1;
                            dn_msg <= '{tag: {2'b00, p_idx, ph}, data: out_val};
                        end
                        if (ph == 2'h2 || !p_en) begin
                            ph <= 2'h0;
                            if (p_idx == P_Z) begin
                                st <= S_EXTRA;
                            end else begin
                                p_idx <= p_idx + 4'h1;
                            end
                        end else begin
                            ph <= ph + 2'h1;
                        end
                    end
                end
                S_EXTRA: begin
                    if (free) begin
                        dn_valid <= 1'b1;
                        dn_msg.tag <= T_EXTRA;
                        dn_msg.data <= '0;
                        dn_msg.data[X_DIAM] <= held_mode[M_DIAM];
                        dn_msg.data[X_FINEY] <= held_mode[M_FINEY] && held_cmd[C_FINEY];
                        dn_msg.data[X_ZW+:2] <= held_mode[M_ZW+:2];
                        dn_msg.data[X_CORD] <= held_mode[M_CORD];
                        dn_msg.data[X_LINE] <= held_kind != K_TRI;
                        dn_msg.data[X_REV] <= held_kind == K_LREV;
                        st <= (cur_draw && held_mode[M_SUPPRESS_RENDER]) ? S_IDLE : S_RENDER;
                    end
                end
                S_RENDER: begin
                    if (free) begin
                        dn_valid <= 1'b1;
                        dn_msg <= '{tag: T_RENDER, data: held_cmd};
                        st <= S_CONT;
                    end
                end
                S_CONT: begin
                    if (free) begin
                        dn_valid <= 1'b1;
                        dn_msg <= '{tag: T_CONT, data: 32'h0};
                        st <= S_IDLE;
                    end
                end
                default: st <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_render;
        dn_valid && dn_msg.tag == T_RENDER;
    endsequence
    sequence s_cont;
        dn_valid && dn_msg.tag == T_CONT;
    endsequence
    property p_render_cont;
        @(posedge hclk) disable iff (!hresetn) s_render ##0 dn_ready |=> s_cont;
    endproperty
    a_render_cont: assert property (p_render_cont) else $error("no continue after render");
    property p_no_draw;
        @(posedge hclk) disable iff (!hresetn) s_render |-> !(cur_draw && held_mode[M_SUPPRESS_RENDER]);
    endproperty
    a_no_draw: assert property (p_no_draw) else $error("render sent while suppressed");
    property p_tex_gate;
        @(posedge hclk) disable iff (!hresetn)
        dn_valid && dn_msg.tag[7:6] == 2'b00 && dn_msg.tag[5:2] <= P_Q
        |-> held_cmd[C_TEX] && held_mode[M_TEX];
    endproperty
    a_tex_gate: assert property (p_tex_gate) else $error("texture sent while disabled");
    property p_fog_gate;
        @(posedge hclk) disable iff (!hresetn) dn_valid && dn_msg.tag == {2'b00, P_FOG, 2'h0}
        |-> held_cmd[C_FOG] && held_mode[M_FOG];
    endproperty
    a_fog_gate: assert property (p_fog_gate) else $error("fog sent while disabled");
    property p_col_gate;
        @(posedge hclk) disable iff (!hresetn) dn_valid && dn_msg.tag[7:6] == 2'b00
        && dn_msg.tag[5:2] >= P_R && dn_msg.tag[5:2] <= P_A |-> held_mode[M_COL];
    endproperty
    a_col_gate: assert property (p_col_gate) else $error("color sent while disabled");
    property p_norm_range;
        @(posedge hclk) disable iff (!hresetn) dn_valid && dn_msg.tag[7:6] == 2'b00
        && dn_msg.tag[5:2] <= P_Q && held_mode[M_TEXP+:2] == TEXP_NORM
        |-> dn_msg.data[30:0] <= F_ONE[30:0];
    endproperty
    a_norm_range: assert property (p_norm_range) else $error("normalized value above one");
    property p_redo_mode;
        @(posedge hclk) disable iff (!hresetn) launch && !cmd_draw
        |=> $stable(held_mode) && $stable(held_cmd) ##1 $stable(held_mode);
    endproperty
    a_redo_mode: assert property (p_redo_mode) else $error("redo changed held mode");
    property p_cull;
        @(posedge hclk) disable iff (!hresetn) st == S_CULL && cull_hit
        |=> st == S_IDLE && culled ##1 !(dn_valid && dn_msg.tag[7:6] == 2'b00);
    endproperty
    a_cull: assert property (p_cull) else $error("culled triangle not dropped");
    property p_line_rev;
        @(posedge hclk) disable iff (!hresetn) dn_valid && held_kind == K_LREV
        && dn_msg.tag == {2'b00, P_X, 2'h0} |-> dn_msg.data == snap[1][P_X];
    endproperty
    a_line_rev: assert property (p_line_rev) else $error("reverse line start wrong");
endmodule : psu_setup_top
